// File: logic/gob_pkg.sv
// Package for the gpio output byte alias block: map, layouts, types
package gob_pkg;

    // Register bus geometry
    localparam int unsigned ADDR_W = 16;  // Byte address width
    localparam int unsigned DATA_W = 32;  // Bus data width
    localparam int unsigned PINS_W = 32;  // Full output word width

    // Alias register byte offsets
    localparam logic [15:0] OFS_ALIAS_8_11    = 16'h1208;
    localparam logic [15:0] OFS_ALIAS_12_15   = 16'h120C;
    localparam logic [15:0] OFS_ALIAS_16_19   = 16'h1210;
    // Control word offsets of our own choosing
    localparam logic [15:0] OFS_FULL_OUTPUT   = 16'h1280;
    localparam logic [15:0] OFS_OUTPUT_ENABLE = 16'h12C0;

    // Lowest pin of each alias group
    localparam int unsigned BASE_8_11  = 8;
    localparam int unsigned BASE_12_15 = 12;
    localparam int unsigned BASE_16_19 = 16;

    // Field positions inside an alias word, lowest pin first
    localparam int unsigned FLD_PIN0 = 0;
    localparam int unsigned FLD_PIN1 = 8;
    localparam int unsigned FLD_PIN2 = 16;
    localparam int unsigned FLD_PIN3 = 24;

    // Values after reset
    localparam logic [31:0] RST_ALIAS  = 32'h0000_0000;
    localparam logic [31:0] RST_OUTPUT = 32'h0000_0000;
    localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

    // Register bus request carrier
    typedef struct packed {
        logic [15:0] addr;   // Byte address
        logic [31:0] wdata;  // Write data
        logic        wr;     // Write strobe
        logic        rd;     // Read strobe
    } gob_bus_req_type;

    // Pad drive carrier
    typedef struct packed {
        logic [31:0] level;  // Driven level
        logic [31:0] oe;     // Output enable, high drives
    } gob_pad_type;

endpackage : gob_pkg

// File: logic/gob_pad_drive.sv
// Pad driver: gates the output word by the output-enable word
`timescale 1ns/1ps
`default_nettype none
module gob_pad_drive
    import gob_pkg::*;
#(
    parameter int unsigned WIDTH = 32  // Pin count
) (
    input  wire logic             clock_i,  // 100 MHz clock
    input  wire logic             srst_i,   // Sync reset, high
    input  wire logic [WIDTH-1:0] out_i,    // Full output word
    input  wire logic [WIDTH-1:0] oe_i,     // Output enable word
    output logic      [WIDTH-1:0] pad_o,    // Pad level
    output logic      [WIDTH-1:0] pad_oe_o  // Pad enable, high drives
);

    ////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [WIDTH-1:0] pad;  // Registered level
        logic [WIDTH-1:0] oe;   // Registered enable
    } gob_drv_state_type;

    gob_drv_state_type state_reg;   // Current state
    gob_drv_state_type state_next;  // Next state

    // Level is stored bit gated by enable; pin driven only when enabled
    always_comb begin
        state_next     = state_reg;
        state_next.pad = out_i & oe_i;
        state_next.oe  = oe_i;
    end

    // Register the copy
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pad_o    = state_reg.pad;
    assign pad_oe_o = state_reg.oe;

    ////////////////////////////////////////////////////////////////////
    // Checks
    a_pad_follows_en: assert property (
        @(posedge clock_i) disable iff (srst_i)
        ##1 pad_oe_o == $past(oe_i)
            && pad_o == ($past(out_i) & $past(oe_i)))
        else $error("pad level or enable does not follow words");

    a_pad_off_low: assert property (
        @(posedge clock_i) disable iff (srst_i)
        (pad_oe_o & pad_o) == pad_o)
        else $error("pad level high while not driven");

endmodule : gob_pad_drive
`default_nettype wire

// File: logic/gob_alias_top.sv
// Output data word with byte-lane alias writes for pins 8 to 19
//
// Operation
// - Alias 0x1208 writes output bits 11..8
// - Alias 0x120C writes output bits 15..12
// - Alias 0x1210 writes output bits 19..16
// - Pins sit at bits 0,8,16,24
// - Stored bit drives pin only when enabled
// - Alias fields write-only, reset to zero
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module gob_alias_top
    import gob_pkg::*;
(
    input  wire logic        clock_i,    // 100 MHz clock
    input  wire logic        srst_i,     // Sync reset, high
    input  wire logic [15:0] addr_i,     // Byte address
    input  wire logic [31:0] wdata_i,    // Write data
    input  wire logic        wr_i,       // Write strobe
    input  wire logic        rd_i,       // Read strobe
    output logic      [31:0] rdata_o,    // Read data, cycle after strobe
    output logic      [31:0] out_word_o, // Full output word
    output logic      [31:0] pad_o,      // Pin levels
    output logic      [31:0] pad_oe_o    // Pin enables, high drives
);

    ////////////////////////////////////////////////////////////////////
    // Helpers

    // Gather the four pin bits of an alias word
    function automatic logic [3:0] alias_bits(input logic [31:0] w);
        alias_bits = {w[FLD_PIN3], w[FLD_PIN2], w[FLD_PIN1], w[FLD_PIN0]};
    endfunction : alias_bits

    // Merge four bits into the word at a group base
    function automatic logic [31:0] merge4(input logic [31:0] word,
                                           input logic [3:0]  bits,
                                           input int unsigned base);
        logic [31:0] res;
        res = word;
        for (int i = 0; i < 4; i++) begin
            res[base + i] = bits[i];
        end
        merge4 = res;
    endfunction : merge4

    ////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [31:0] out_word;  // Full output word
        logic [31:0] oe_word;   // Output enable word
        logic [31:0] rdata;     // Read answer
    } gob_state_type;

    gob_state_type   state_reg;   // Current state
    gob_state_type   state_next;  // Next state
    gob_bus_req_type req;         // Bundled bus request

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // Decode writes and reads
    always_comb begin
        state_next       = state_reg;
        state_next.rdata = RD_UNMAPPED;
        if (req.wr) begin
            unique case (req.addr)
                OFS_ALIAS_8_11: begin
                    state_next.out_word = merge4(state_reg.out_word,
                        alias_bits(req.wdata), BASE_8_11);
                end
                OFS_ALIAS_12_15: begin
                    state_next.out_word = merge4(state_reg.out_word,
                        alias_bits(req.wdata), BASE_12_15);
                end
                OFS_ALIAS_16_19: begin
                    state_next.out_word = merge4(state_reg.out_word,
                        alias_bits(req.wdata), BASE_16_19);
                end
                OFS_FULL_OUTPUT: begin
                    state_next.out_word = req.wdata;  // Whole word
                end
                OFS_OUTPUT_ENABLE: begin
                    state_next.oe_word = req.wdata;   // Enable word
                end
                default: begin
                    state_next.out_word = state_reg.out_word;  // Ignored
                end
            endcase
        end
        if (req.rd) begin
            unique case (req.addr)
                OFS_FULL_OUTPUT: begin
                    state_next.rdata = state_reg.out_word;  // Stored output word
                end
                OFS_OUTPUT_ENABLE: begin
                    state_next.rdata = state_reg.oe_word;
                end
                default: begin
                    state_next.rdata = RD_UNMAPPED;  // Aliases read zero
                end
            endcase
        end
    end

    // Register the copy; all words clear on reset
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state_reg.out_word <= RST_OUTPUT;
            state_reg.oe_word  <= RST_ENABLE;
            state_reg.rdata    <= RST_ALIAS;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata_o    = state_reg.rdata;
    assign out_word_o = state_reg.out_word;

    ////////////////////////////////////////////////////////////////////
    // Pad drive
    gob_pad_drive #(
        .WIDTH (PINS_W)
    ) u_pad (
        .clock_i  (clock_i),
        .srst_i   (srst_i),
        .out_i    (state_reg.out_word),
        .oe_i     (state_reg.oe_word),
        .pad_o    (pad_o),
        .pad_oe_o (pad_oe_o)
    );

    ////////////////////////////////////////////////////////////////////
    // Checks
    a_alias_lo_write: assert property (
        @(posedge clock_i) disable iff (srst_i)
        wr_i && addr_i == OFS_ALIAS_8_11 |=> out_word_o[11:8] ==
        {$past(wdata_i[24]), $past(wdata_i[16]),
         $past(wdata_i[8]), $past(wdata_i[0])})
        else $error("alias 8-11 write not applied");

    a_alias_mid_write: assert property (
        @(posedge clock_i) disable iff (srst_i)
        wr_i && addr_i == OFS_ALIAS_12_15 |=> out_word_o[15:12] ==
        {$past(wdata_i[24]), $past(wdata_i[16]),
         $past(wdata_i[8]), $past(wdata_i[0])})
        else $error("alias 12-15 write not applied");

    a_alias_hi_write: assert property (
        @(posedge clock_i) disable iff (srst_i)
        wr_i && addr_i == OFS_ALIAS_16_19 |=> out_word_o[19:16] ==
        {$past(wdata_i[24]), $past(wdata_i[16]),
         $past(wdata_i[8]), $past(wdata_i[0])})
        else $error("alias 16-19 write not applied");

    a_top_pin_lane: assert property (
        @(posedge clock_i) disable iff (srst_i)
        wr_i && addr_i == OFS_ALIAS_8_11 && wdata_i == 32'h0100_0000
        |=> out_word_o[11:8] == 4'h8)
        else $error("highest pin not taken from bit 24");

    a_alias_keeps_rest: assert property (
        @(posedge clock_i)
        disable iff (srst_i)
        wr_i && (addr_i == OFS_ALIAS_8_11 || addr_i == OFS_ALIAS_12_15
                 || addr_i == OFS_ALIAS_16_19)
        |=> out_word_o[31:20] == $past(out_word_o[31:20])
            && out_word_o[7:0] == $past(out_word_o[7:0]))
        else $error("alias write disturbed other pins");

    a_alias_reads_zero: assert property (
        @(posedge clock_i)
        disable iff (srst_i)
        rd_i && (addr_i == OFS_ALIAS_8_11 || addr_i == OFS_ALIAS_12_15
                 || addr_i == OFS_ALIAS_16_19)
        |=> rdata_o == 32'h0000_0000)
        else $error("write-only alias returned data");

    a_reset_clears: assert property (
        @(posedge clock_i)
        srst_i |=> out_word_o == 32'h0000_0000
            && rdata_o == 32'h0000_0000)
        else $error("output word not cleared by reset");

    a_pin_drive: assert property (
        @(posedge clock_i) disable iff (srst_i)
        ##1 pad_o == ($past(out_word_o) & $past(state_reg.oe_word)))
        else $error("pin level disagrees with stored bit and enable");

    // Plain cycles leave the output word alone
    a_idle_keeps_word: assert property (
        @(posedge clock_i) disable iff (srst_i)
        !wr_i |=> out_word_o == $past(out_word_o))
        else $error("output word moved without a write");

    // Alias writes never touch the enable word
    a_alias_keeps_en: assert property (
        @(posedge clock_i) disable iff (srst_i)
        wr_i && (addr_i == OFS_ALIAS_8_11 || addr_i == OFS_ALIAS_12_15
                 || addr_i == OFS_ALIAS_16_19)
        |=> state_reg.oe_word == $past(state_reg.oe_word))
        else $error("alias write disturbed the enable word");

    // Lowest pin of the top group comes from bit 0
    a_low_pin_lane: assert property (
        @(posedge clock_i) disable iff (srst_i)
        wr_i && addr_i == OFS_ALIAS_16_19 && wdata_i == 32'h0000_0001
        |=> out_word_o[19:16] == 4'h1)
        else $error("lowest pin not taken from bit 0");

    // Read data stand only in the cycle after a read
    a_rdata_idle_zero: assert property (
        @(posedge clock_i) disable iff (srst_i)
        !rd_i |=> rdata_o == RD_UNMAPPED)
        else $error("read data present without a read");

    // Unmapped writes leave both words alone
    a_unmapped_ignored: assert property (
        @(posedge clock_i) disable iff (srst_i)
        wr_i && addr_i != OFS_ALIAS_8_11 && addr_i != OFS_ALIAS_12_15
        && addr_i != OFS_ALIAS_16_19 && addr_i != OFS_FULL_OUTPUT
        && addr_i != OFS_OUTPUT_ENABLE
        |=> out_word_o == $past(out_word_o)
            && state_reg.oe_word == $past(state_reg.oe_word))
        else $error("unmapped write changed a word");

endmodule : gob_alias_top
`default_nettype wire

// File: bench/tb_gob_alias_top.sv
// Self-checking bench for the gpio output byte alias block
`timescale 1ns/1ps
`default_nettype none
module tb_gob_alias_top
    import gob_pkg::*;
;
    logic        clock_i;    // Bench clock
    logic        srst_i;     // Sync reset
    logic [15:0] addr_i;     // Bus address
    logic [31:0] wdata_i;    // Bus write data
    logic        wr_i;       // Write strobe
    logic        rd_i;       // Read strobe
    logic [31:0] rdata_o;    // Read data
    logic [31:0] out_word_o; // Full output word
    logic [31:0] pad_o;      // Pin levels
    logic [31:0] pad_oe_o;   // Pin enables
    logic        rd_q = 1'b0; // Read taken last edge
    logic        pchk;       // Pin check due
    logic [15:0] seed;       // Random state
    logic [31:0] rnd;        // Random word
    logic [31:0] out_m;      // Expected output word
    logic [31:0] en_m;       // Expected enable word
    logic [31:0] rq[$];      // Expected read data
    logic [31:0] pq[$];      // Expected word, pads, enables
    int          bad_count = 0;  // Mismatches
    int          n_tests   = 0;  // Comparisons
    int          cyc       = 0;  // Cycle count for hang guard
    logic [15:0] amap [6];   // Aliases, control words, one unmapped

    gob_alias_top dut_u (
        .clock_i    (clock_i),
        .srst_i     (srst_i),
        .addr_i     (addr_i),
        .wdata_i    (wdata_i),
        .wr_i       (wr_i),
        .rd_i       (rd_i),
        .rdata_o    (rdata_o),
        .out_word_o (out_word_o),
        .pad_o      (pad_o),
        .pad_oe_o   (pad_oe_o)
    );

    ////////////////////////////////////////////////////////////////////
    // Clock, 10 ns period
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    ////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
    endfunction : lfsr

    // Pin-side results: output word, pad levels, pad enables
    task automatic cmp_pin(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_pin

    // Bus-side results: read data
    task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected rdata_o expected %h seen %h", e, g);
        end
    endtask : cmp_rd

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    // Write cycle; model follows the alias map
    task automatic bus_wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i    <= 1'b0;
        if (a == OFS_FULL_OUTPUT) out_m = d;
        if (a == OFS_OUTPUT_ENABLE) en_m = d;
        for (int i = 0; i < 3; i++) begin
            for (int j = 0; j < 4; j++) begin
                if (a == amap[i]) out_m[8 + 4 * i + j] = d[8 * j];
            end
        end
    endtask : bus_wr

    // Read cycle; expectation noted first
    task automatic bus_rd(input logic [15:0] a, input logic [31:0] e);
        rq.push_back(e);
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clock_i);
        rd_i   <= 1'b0;
    endtask : bus_rd

    // Let pins settle, then note expected word and pads
    task automatic settle;
        repeat (3) @(posedge clock_i);
        pq.push_back(out_m);
        pq.push_back(out_m & en_m);
        pq.push_back(en_m);
        pchk <= 1'b1;
        @(posedge clock_i);
        pchk <= 1'b0;
    endtask : settle

    task automatic reset_dut;
        srst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        srst_i <= 1'b0;
        out_m = RST_OUTPUT;
        en_m  = RST_ENABLE;
    endtask : reset_dut

    ////////////////////////////////////////////////////////////////////
    // Watcher: compare each result against the oldest note
    always @(posedge clock_i) begin
        rd_q <= rd_i;
        cyc  <= cyc + 1;
        if (rd_q) cmp_rd(rq.pop_front(), rdata_o);
        if (pchk) begin
            cmp_pin("out_word_o", pq.pop_front(), out_word_o);
            cmp_pin("pad_o", pq.pop_front(), pad_o);
            cmp_pin("pad_oe_o", pq.pop_front(), pad_oe_o);
        end
        if (cyc == 5000) begin
            bad_count++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        amap = '{OFS_ALIAS_8_11, OFS_ALIAS_12_15, OFS_ALIAS_16_19,
                 OFS_FULL_OUTPUT, OFS_OUTPUT_ENABLE, 16'h1300};
        {wr_i, rd_i, pchk} = 3'h0;
        addr_i = 16'h0000;
        wdata_i = 32'h0000_0000;
        seed = 16'hE35B;
        rnd = 32'h0000_0000;
        srst_i = 1'b1;
        reset_dut();
        // Reset state; aliases read back zero
        for (int i = 0; i < 6; i++) bus_rd(amap[i], RST_ALIAS);
        settle();
        // Reserved alias bits set, pin bits clear
        bus_wr(OFS_FULL_OUTPUT, 32'hFFFF_FFFF);
        bus_wr(OFS_OUTPUT_ENABLE, 32'h000F_0F00);
        for (int i = 0; i < 3; i++) bus_wr(amap[i], 32'hFEFE_FEFE);
        // Single pin lanes: top pin of 8-11, bottom pin of 16-19
        bus_wr(OFS_ALIAS_8_11, 32'h0100_0000);
        bus_wr(OFS_ALIAS_16_19, 32'h0000_0001);
        bus_rd(OFS_OUTPUT_ENABLE, 32'h000F_0F00);
        settle();
        // Random traffic over every address
        for (int k = 0; k < 60; k++) begin
            seed = lfsr(seed);
            rnd[15:0] = seed;
            seed = lfsr(seed);
            rnd[31:16] = seed;
            seed = lfsr(seed);
            bus_wr(amap[seed % 16'h0006], rnd);
            bus_rd(OFS_FULL_OUTPUT, out_m);
            bus_rd(OFS_OUTPUT_ENABLE, en_m);
            bus_rd(amap[k % 3], RST_ALIAS);
            settle();
        end
        // Reset in mid-run clears everything
        reset_dut();
        bus_rd(OFS_FULL_OUTPUT, RST_OUTPUT);
        settle();
        print_verdict();
    end
endmodule : tb_gob_alias_top
`default_nettype wire
